// ---- include/adf_consts.vh ----
// Constants for the amplifier diagnostic and fault status register bank.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef ADF_CONSTS_VH
`define ADF_CONSTS_VH

// Register indices; byte address is four times the index
`define ADF_IDX_DIAG34     6'h0d
`define ADF_IDX_LINE_DET   6'h0e
`define ADF_IDX_CH_STATE   6'h0f
`define ADF_IDX_CH_FAULT   6'h10
`define ADF_IDX_GLB_FAULT  6'h11
`define ADF_IDX_THERM_SD   6'h12
`define ADF_IDX_WARN       6'h13
`define ADF_IDX_STATE_REQ  6'h20
`define ADF_IDX_DIAG_CTRL  6'h21
`define ADF_IDX_IRQ_STAT   6'h22
`define ADF_IDX_IRQ_MASK   6'h23

// Reset values
`define ADF_RST_ZERO       8'h00
`define ADF_RST_CH_STATE   8'h55
`define ADF_RST_WARN       8'h20
`define ADF_RST_STATE_REQ  8'h55
`define ADF_RST_IRQ        5'h00

// Channel states
`define ADF_ST_PLAY        2'h0
`define ADF_ST_HIZ         2'h1
`define ADF_ST_MUTE        2'h2
`define ADF_ST_DIAG        2'h3

// Field positions
`define ADF_WARN_POR_BIT   5
`define ADF_DCTRL_INH_BIT  0
`define ADF_IRQ_CH_FAULT   0
`define ADF_IRQ_GLB_FAULT  1
`define ADF_IRQ_THERM_SD   2
`define ADF_IRQ_WARN       3
`define ADF_IRQ_DIAG_DONE  4
`define ADF_IRQ_W          5

// AXI responses
`define ADF_RESP_OKAY      2'h0
`define ADF_RESP_DECERR    2'h3

`endif

// ---- logic/adf_chan_state.v ----
// One channel's operating-state tracker with automatic diagnostic entry.
// Assumes the diagnostic engine answers a start pulse with a done pulse.
`timescale 1ns/1ps
`default_nettype none
`include "adf_consts.vh"

module adf_chan_state (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire [1:0] req_state,
	input  wire       inhibit,
	input  wire       fault,
	input  wire       diag_done,
	output reg  [1:0] state_r,
	output reg        diag_start_r
);

	reg [1:0] prev_req_r;
	reg [1:0] state_nxt;
	reg       start_nxt;

	always @* begin
		state_nxt = state_r;
		start_nxt = 1'b0;
		case (state_r)
			`ADF_ST_DIAG: begin
				// Manual request stays parked in Hi-Z so it does not loop
				if (diag_done) begin
					state_nxt = (req_state == `ADF_ST_DIAG) ? `ADF_ST_HIZ : req_state;
				end
			end
			`ADF_ST_PLAY, `ADF_ST_HIZ, `ADF_ST_MUTE: begin
				if (fault && state_r != `ADF_ST_HIZ) begin
					state_nxt = inhibit ? `ADF_ST_HIZ : `ADF_ST_DIAG; // [R11]
					start_nxt = !inhibit; // [R11]
				end else if (req_state == `ADF_ST_DIAG && prev_req_r != `ADF_ST_DIAG) begin
					state_nxt = `ADF_ST_DIAG; // [R10]
					start_nxt = 1'b1;
				end else if (req_state != `ADF_ST_DIAG && req_state != state_r) begin
					if (state_r == `ADF_ST_HIZ && !inhibit) begin
						state_nxt = `ADF_ST_DIAG; // [R11]
						start_nxt = 1'b1;
					end else begin
						state_nxt = req_state; // [R10]
					end
				end
			end
			default: begin
				state_nxt = `ADF_ST_HIZ;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_r      <= `ADF_ST_HIZ;
			prev_req_r   <= `ADF_ST_HIZ;
			diag_start_r <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			prev_req_r   <= req_state;
			diag_start_r <= start_nxt;
		end
	end

endmodule // adf_chan_state
`default_nettype wire

// ---- logic/adf_status_regs.v ----
// Diagnostic and fault status bank with writable control registers, AXI4-Lite slave and interrupt.
// Assumes detector inputs are synchronous to aclk and hold their latest result.
//
// Contract
// [R1] Channel 3/4 diagnostic nibbles: short-ground, short-supply, open, shorted load.
// [R2] Line-level detect bits 3..0 for channels 1..4; upper nibble reads zero.
// [R3] Two-bit present state per channel, channel 1 highest: play, hi-z, mute, diag.
// [R4] Channel state report reads 0x55 after reset.
// [R5] Overcurrent ch1..4 in bits 7..4, DC fault ch1..4 in bits 3..0, reset zero.
// [R6] Global faults: clock, stage OV, battery OV, stage UV, battery UV in bits 4..0.
// [R7] Global thermal shutdown bit 4, per-channel shutdown bits 3..0.
// [R8] Warnings: power-on reset bit 5, global and per-channel thermal warnings.
// [R9] Warning register resets to 0x20 with power-on indication set.
// [R10] Requested state uses the same encoding, defaulting to hi-z.
// [R11] Diagnostics run on leaving hi-z and after fault unless inhibited.
// [R12] Status registers ignore writes and show the latest detector result; the warning register's power-on bit is held until read.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adf_consts.vh"

module adf_status_regs (
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite slave
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Detector results
	input  wire [3:0]  short_to_ground_flag,
	input  wire [3:0]  short_to_supply_flag,
	input  wire [3:0]  open_load_flag,
	input  wire [3:0]  shorted_load_flag,
	input  wire [3:0]  line_level_detect,
	input  wire [3:0]  overcurrent_flag,
	input  wire [3:0]  dc_offset_flag,
	input  wire        invalid_clock,
	input  wire        stage_supply_overvoltage,
	input  wire        battery_overvoltage,
	input  wire        stage_supply_undervoltage,
	input  wire        battery_undervoltage,
	input  wire        global_thermal_shutdown,
	input  wire [3:0]  thermal_shutdown_flag,
	input  wire        logic_supply_por_event,
	input  wire        global_thermal_warning,
	input  wire [3:0]  thermal_warning_flag,
	input  wire [3:0]  diag_done,
	// Block outputs
	output reg  [3:0]  diag_start_r,
	output reg         irq_r
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function [7:0] rise8;
		input [7:0] cur;
		input [7:0] prev;
		begin
			rise8 = cur & ~prev;
		end
	endfunction

	function [5:0] word_idx;
		input [7:0] addr;
		begin
			word_idx = addr[7:2];
		end
	endfunction

	function mapped;
		input [5:0] idx;
		begin
			mapped = (idx >= `ADF_IDX_DIAG34 && idx <= `ADF_IDX_WARN) ||
				(idx >= `ADF_IDX_STATE_REQ && idx <= `ADF_IDX_IRQ_MASK);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Status registers

	reg [7:0]            diag34_r;
	reg [3:0]            line_det_r;
	reg [7:0]            ch_fault_r;
	reg [4:0]            glb_fault_r;
	reg [4:0]            therm_sd_r;
	reg [4:0]            therm_warn_r;
	reg                  por_seen_r;
	reg [7:0]            state_req_r;
	reg                  auto_diag_inhibit_r;
	reg [`ADF_IRQ_W-1:0] irq_stat_r;
	reg [`ADF_IRQ_W-1:0] irq_mask_r;

	wire [7:0] ch_state_report;
	wire [7:0] warn_word;
	wire [3:0] start_w;

	// Per-channel nibble: short-ground, short-supply, open, shorted (high to low)
	wire [7:0] diag34_nxt = {short_to_ground_flag[2], short_to_supply_flag[2], // [R1]
		open_load_flag[2], shorted_load_flag[2],
		short_to_ground_flag[3], short_to_supply_flag[3],
		open_load_flag[3], shorted_load_flag[3]};

	// Port bit n is channel n+1; register places channel 1 highest
	wire [7:0] ch_fault_nxt = {overcurrent_flag[0], overcurrent_flag[1], // [R5]
		overcurrent_flag[2], overcurrent_flag[3],
		dc_offset_flag[0], dc_offset_flag[1], dc_offset_flag[2], dc_offset_flag[3]};

	wire [3:0] line_det_nxt = {line_level_detect[0], line_level_detect[1], // [R2]
		line_level_detect[2], line_level_detect[3]};

	wire [4:0] glb_fault_nxt = {invalid_clock, stage_supply_overvoltage, // [R6]
		battery_overvoltage, stage_supply_undervoltage, battery_undervoltage};

	wire [4:0] therm_sd_nxt = {global_thermal_shutdown, thermal_shutdown_flag[0], // [R7]
		thermal_shutdown_flag[1], thermal_shutdown_flag[2], thermal_shutdown_flag[3]};

	wire [4:0] therm_warn_nxt = {global_thermal_warning, thermal_warning_flag[0], // [R8]
		thermal_warning_flag[1], thermal_warning_flag[2], thermal_warning_flag[3]};

	assign warn_word = {2'b00, por_seen_r, therm_warn_r}; // [R8]

	////////////////////////////////////////////////////////////////////////
	// Channel state trackers

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_ch
			adf_chan_state u_state (
				.aclk         (aclk),
				.aresetn      (aresetn),
				.req_state    (state_req_r[7-2*gi -: 2]),
				.inhibit      (auto_diag_inhibit_r),
				.fault        (overcurrent_flag[gi] | dc_offset_flag[gi]),
				.diag_done    (diag_done[gi]),
				.state_r      (ch_state_report[7-2*gi -: 2]), // [R3] [R4]
				.diag_start_r (start_w[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path

	reg       aw_got_r;
	reg       w_got_r;
	reg [5:0] aw_idx_r;
	reg [7:0] wbyte_r;
	reg       wlane0_r;

	wire do_write = aw_got_r && w_got_r && !s_axi_bvalid;
	wire wr_ctl   = do_write && wlane0_r;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `ADF_RESP_OKAY;
			aw_got_r      <= 1'b0;
			w_got_r       <= 1'b0;
			aw_idx_r      <= 6'h00;
			wbyte_r       <= `ADF_RST_ZERO;
			wlane0_r      <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_idx_r      <= word_idx(s_axi_awaddr);
				aw_got_r      <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wbyte_r      <= s_axi_wdata[7:0];
				wlane0_r     <= s_axi_wstrb[0];
				w_got_r      <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_got_r     <= 1'b0;
				w_got_r      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(aw_idx_r) ? `ADF_RESP_OKAY : `ADF_RESP_DECERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path

	wire       rd_take = s_axi_arvalid && s_axi_arready;
	wire [5:0] rd_idx  = word_idx(s_axi_araddr);
	reg  [7:0] rd_byte;

	always @* begin
		case (rd_idx)
			`ADF_IDX_DIAG34:    rd_byte = diag34_r;
			`ADF_IDX_LINE_DET:  rd_byte = {4'h0, line_det_r};
			`ADF_IDX_CH_STATE:  rd_byte = ch_state_report;
			`ADF_IDX_CH_FAULT:  rd_byte = ch_fault_r;
			`ADF_IDX_GLB_FAULT: rd_byte = {3'h0, glb_fault_r};
			`ADF_IDX_THERM_SD:  rd_byte = {3'h0, therm_sd_r};
			`ADF_IDX_WARN:      rd_byte = warn_word;
			`ADF_IDX_STATE_REQ: rd_byte = state_req_r;
			`ADF_IDX_DIAG_CTRL: rd_byte = {7'h00, auto_diag_inhibit_r};
			`ADF_IDX_IRQ_STAT:  rd_byte = {3'h0, irq_stat_r};
			`ADF_IDX_IRQ_MASK:  rd_byte = {3'h0, irq_mask_r};
			default:            rd_byte = `ADF_RST_ZERO;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `ADF_RESP_OKAY;
		end else begin
			if (rd_take) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= {24'h000000, rd_byte};
				s_axi_rresp   <= mapped(rd_idx) ? `ADF_RESP_OKAY : `ADF_RESP_DECERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status capture; bus writes never reach these

	// Power-on flag is sticky so software can see it; a read of warnings
	// clears it, but a new event in the same cycle keeps it set
	wire por_rd_clr = rd_take && rd_idx == `ADF_IDX_WARN;
	wire [7:0] warn_reset_val = `ADF_RST_WARN;

	always @(posedge aclk) begin
		if (!aresetn) begin
			diag34_r     <= `ADF_RST_ZERO;
			line_det_r   <= 4'h0;
			ch_fault_r   <= `ADF_RST_ZERO; // [R5]
			glb_fault_r  <= 5'h00;
			therm_sd_r   <= 5'h00;
			therm_warn_r <= 5'h00;
			por_seen_r   <= warn_reset_val[`ADF_WARN_POR_BIT]; // [R9]
		end else begin
			diag34_r     <= diag34_nxt; // [R12]
			line_det_r   <= line_det_nxt; // [R12]
			ch_fault_r   <= ch_fault_nxt; // [R12]
			glb_fault_r  <= glb_fault_nxt; // [R12]
			therm_sd_r   <= therm_sd_nxt; // [R12]
			therm_warn_r <= therm_warn_nxt; // [R12]
			if (logic_supply_por_event) begin
				por_seen_r <= 1'b1; // [R8]
			end else if (por_rd_clr) begin
				por_seen_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_req_r         <= `ADF_RST_STATE_REQ; // [R10]
			auto_diag_inhibit_r <= 1'b0; // [R11]
			irq_mask_r          <= `ADF_RST_IRQ;
		end else if (wr_ctl) begin
			case (aw_idx_r)
				`ADF_IDX_STATE_REQ: state_req_r <= wbyte_r; // [R10]
				`ADF_IDX_DIAG_CTRL: auto_diag_inhibit_r <= wbyte_r[`ADF_DCTRL_INH_BIT]; // [R11]
				`ADF_IDX_IRQ_MASK:  irq_mask_r <= wbyte_r[`ADF_IRQ_W-1:0];
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupts

	reg  [7:0] ch_fault_q_r;
	reg  [4:0] glb_fault_q_r;
	reg  [4:0] therm_sd_q_r;
	reg  [5:0] warn_q_r;
	wire [7:0] warn_rise = rise8({2'b00, por_seen_r, therm_warn_r}, {2'b00, warn_q_r});
	wire [7:0] sd_rise   = rise8({3'h0, therm_sd_r}, {3'h0, therm_sd_q_r});
	wire [7:0] glb_rise  = rise8({3'h0, glb_fault_r}, {3'h0, glb_fault_q_r});
	wire [`ADF_IRQ_W-1:0] irq_evt;
	wire [`ADF_IRQ_W-1:0] irq_clr;
	wire [`ADF_IRQ_W-1:0] irq_stat_nxt;

	assign irq_evt[`ADF_IRQ_CH_FAULT]  = |rise8(ch_fault_r, ch_fault_q_r);
	assign irq_evt[`ADF_IRQ_GLB_FAULT] = |glb_rise;
	assign irq_evt[`ADF_IRQ_THERM_SD]  = |sd_rise;
	assign irq_evt[`ADF_IRQ_WARN]      = |warn_rise;
	assign irq_evt[`ADF_IRQ_DIAG_DONE] = |diag_done;

	assign irq_clr = (wr_ctl && aw_idx_r == `ADF_IDX_IRQ_STAT) ?
		wbyte_r[`ADF_IRQ_W-1:0] : `ADF_RST_IRQ;
	// Set wins over a write-one clear in the same cycle
	assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_evt;

	always @(posedge aclk) begin
		if (!aresetn) begin
			ch_fault_q_r  <= `ADF_RST_ZERO;
			glb_fault_q_r <= 5'h00;
			therm_sd_q_r  <= 5'h00;
			warn_q_r      <= 6'h00;
			irq_stat_r    <= `ADF_RST_IRQ;
			irq_r         <= 1'b0;
			diag_start_r  <= 4'h0;
		end else begin
			ch_fault_q_r  <= ch_fault_r;
			glb_fault_q_r <= glb_fault_r;
			therm_sd_q_r  <= therm_sd_r;
			warn_q_r      <= {por_seen_r, therm_warn_r};
			irq_stat_r    <= irq_stat_nxt;
			irq_r         <= |(irq_stat_nxt & irq_mask_r);
			diag_start_r  <= start_w; // [R11]
		end
	end

endmodule // adf_status_regs
`default_nettype wire

// ---- tb/adf_status_regs_sva.sv ----
// Checker for the status bank's bus handshake, read data and channel 1 start pulse.
// Assumes it is bound to the bank's top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "adf_consts.vh"
module adf_status_regs_sva (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [3:0]  diag_start_r,
	input wire logic        irq_r
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////
	// Read and write answers must not move while the master stalls; then pulse and reset checks
	AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data moved");
	AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	AST_RD_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("second read accepted");
	AST_RV_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer moved");
	AST_WR_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("second write accepted");
	AST_WR_RESP: assert property (s_axi_bvalid |-> s_axi_bresp inside {`ADF_RESP_OKAY, `ADF_RESP_DECERR})
		else $error("bad write response");
	AST_START_PULSE: assert property (diag_start_r[0] |=> !diag_start_r[0])
		else $error("start pulse too long");
	AST_RST_IDLE: assert property ($rose(aresetn) |-> !irq_r && !s_axi_rvalid && diag_start_r == 4'h0)
		else $error("outputs busy after reset");
endmodule // adf_status_regs_sva
bind adf_status_regs adf_status_regs_sva u_sva (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .diag_start_r(diag_start_r), .irq_r(irq_r));
`default_nettype wire

// ---- tb/adf_status_regs_bench.sv ----
// Self-checking bench for the diagnostic and fault status bank.
// Assumes the design files and adf_consts.vh are on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "adf_consts.vh"
module adf_status_regs_bench;
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic [7:0]  awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, d;
	logic        awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
	wire         awr, wrd, bv, arr, rv, irq;
	wire [1:0]   brs, rrs;
	wire [31:0]  rd;
	wire [3:0]   ds;
	logic [3:0]  sg = 4'h0, sp = 4'h0, ol = 4'h0, sl = 4'h0, ld = 4'h0, oc = 4'h0;
	logic [3:0]  dc = 4'h0, ts = 4'h0, tw = 4'h0, dd = 4'h0;
	logic [4:0]  gf = 5'h00;
	logic        gsd = 1'h0, gw = 1'h0, por = 1'h0;
	logic [1:0]  r;
	logic [3:0]  ws = 4'h1, seen_ds = 4'h0;
	logic        slow = 1'h0;
	integer      failures = 0, checks = 0, i, k, n_start = 0;
	always #5 aclk = ~aclk;
	// Start pulses last one cycle, so they are tallied here rather than polled
	always @(posedge aclk) begin
		if (aresetn) begin
			seen_ds <= seen_ds | ds;
			n_start <= n_start + ds[0] + ds[1] + ds[2] + ds[3];
		end
	end
	adf_status_regs u_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(brs),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rrs), .s_axi_rvalid(rv),
		.s_axi_rready(rry), .short_to_ground_flag(sg), .short_to_supply_flag(sp),
		.open_load_flag(ol), .shorted_load_flag(sl), .line_level_detect(ld),
		.overcurrent_flag(oc), .dc_offset_flag(dc), .invalid_clock(gf[4]),
		.stage_supply_overvoltage(gf[3]), .battery_overvoltage(gf[2]),
		.stage_supply_undervoltage(gf[1]), .battery_undervoltage(gf[0]),
		.global_thermal_shutdown(gsd), .thermal_shutdown_flag(ts),
		.logic_supply_por_event(por), .global_thermal_warning(gw),
		.thermal_warning_flag(tw), .diag_done(dd), .diag_start_r(ds), .irq_r(irq));
	////////////////////////////////////////////////////////////////////////
	// Port bit 0 is channel 1, which sits highest in every per-channel nibble
	function [3:0] rvs(input [3:0] x);
		rvs = {x[0], x[1], x[2], x[3]};
	endfunction
	// POR bit is expected clear: every caller runs after it was read away
	function [7:0] ex(input [5:0] a);
		case (a)
			6'h0d: ex = {sg[2], sp[2], ol[2], sl[2], sg[3], sp[3], ol[3], sl[3]};
			6'h0e: ex = {4'h0, rvs(ld)};
			6'h0f: ex = 8'h55;
			6'h10: ex = {rvs(oc), rvs(dc)};
			6'h11: ex = {3'h0, gf};
			6'h12: ex = {3'h0, gsd, rvs(ts)};
			default: ex = {3'h0, gw, rvs(tw)};
		endcase
	endfunction
	task chk(input [63:0] n, input [31:0] s, input [31:0] e);
		begin
			checks = checks + 1;
			if (s !== e) begin
				failures = failures + 1;
				$display("Error %0s expected %h seen %h", n, e, s);
			end
		end
	endtask
	task final_report;
		begin
			$display("checks %0d failures %0d", checks, failures);
			if (failures == 0 && checks > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	// Address and data are offered together and released as each is taken
	task wr(input [7:0] a, input [7:0] v, output [1:0] q);
		reg fa, fw;
		begin
			fa = 1'h0;
			fw = 1'h0;
			@(posedge aclk);
			awa <= a;
			wd <= {24'h0, v};
			awv <= 1'h1;
			wv <= 1'h1;
			bry <= !slow;
			while (!(fa && fw)) begin
				@(posedge aclk);
				if (awr && !fa) begin
					awv <= 1'h0;
					fa = 1'h1;
				end
				if (wrd && !fw) begin
					wv <= 1'h0;
					fw = 1'h1;
				end
			end
			if (slow) begin
				repeat (2) @(posedge aclk);
				bry <= 1'h1;
			end
			do @(posedge aclk); while (bv !== 1'h1);
			q = brs;
			bry <= 1'h0;
		end
	endtask
	task rdr(input [7:0] a, output [31:0] v, output [1:0] q);
		begin
			@(posedge aclk);
			ara <= a;
			arv <= 1'h1;
			rry <= !slow;
			do @(posedge aclk); while (arr !== 1'h1);
			arv <= 1'h0;
			if (slow) begin
				repeat (2) @(posedge aclk);
				rry <= 1'h1;
			end
			do @(posedge aclk); while (rv !== 1'h1);
			v = rd;
			q = rrs;
			rry <= 1'h0;
		end
	endtask
	task rchk(input [63:0] n, input [7:0] a, input [7:0] e);
		begin
			rdr(a, d, r);
			chk(n, d, {24'h0, e});
			chk("rresp", {30'h0, r}, {30'h0, `ADF_RESP_OKAY});
		end
	endtask
	task sweep;
		integer j;
		for (j = 13; j < 20; j = j + 1)
			rchk("reset", {j[5:0], 2'h0}, j == 15 ? 8'h55 : (j == 19 ? 8'h20 : 8'h00));
	endtask
	task pls(input [3:0] m);
		begin
			@(posedge aclk);
			dd <= m;
			@(posedge aclk);
			dd <= 4'h0;
			repeat (3) @(posedge aclk);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (30000) @(posedge aclk);
		failures = failures + 1;
		final_report;
	end
	initial begin
		i = $urandom(99);
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		sweep;
		@(posedge aclk);
		por <= 1'h1;
		@(posedge aclk);
		por <= 1'h0;
		repeat (3) @(posedge aclk);
		rchk("por", 8'h4c, 8'h20);
		rchk("por", 8'h4c, 8'h00);
		// All-ones and all-zeros first, then random detector levels
		for (k = 0; k < 16; k = k + 1) begin
			d = k == 0 ? 32'hffffffff : (k == 1 ? 32'h0 : $urandom);
			@(posedge aclk);
			{sg, sp, ol, sl, ld, oc, dc, ts} <= d;
			{tw, gf, gsd, gw} <= d[10:0];
			repeat (3) @(posedge aclk);
			// Odd rounds hold back bready and rready so the answers must wait
			slow = k[0];
			for (i = 13; i < 20; i = i + 1) begin
				d = $urandom;
				wr({i[5:0], 2'h0}, d[7:0], r);
				chk("wresp", {30'h0, r}, {30'h0, `ADF_RESP_OKAY});
				rchk("status", {i[5:0], 2'h0}, ex(i[5:0]));
			end
		end
		slow = 1'h0;
		@(posedge aclk);
		{sg, sp, ol, sl, ld, oc, dc, ts} <= 32'h0;
		{tw, gf, gsd, gw} <= 11'h000;
		wr(8'hfc, 8'h5a, r);
		chk("wdecerr", {30'h0, r}, {30'h0, `ADF_RESP_DECERR});
		rdr(8'hfc, d, r);
		chk("rdecerr", d, 32'h0);
		chk("rdecerr", {30'h0, r}, {30'h0, `ADF_RESP_DECERR});
		wr(8'h84, 8'h01, r);
		wr(8'h80, 8'h27, r);
		rchk("state", 8'h3c, 8'h27);
		pls(4'h8);
		rchk("state", 8'h3c, 8'h25);
		wr(8'h84, 8'h00, r);
		wr(8'h80, 8'h55, r);
		rchk("state", 8'h3c, 8'h55);
		wr(8'h80, 8'h95, r);
		rchk("state", 8'h3c, 8'hd5);
		pls(4'h1);
		rchk("state", 8'h3c, 8'h95);
		@(posedge aclk);
		oc <= 4'h1;
		@(posedge aclk);
		oc <= 4'h0;
		repeat (3) @(posedge aclk);
		rchk("state", 8'h3c, 8'hd5);
		pls(4'h1);
		rchk("state", 8'h3c, 8'h95);
		chk("start", {28'h0, seen_ds}, 32'h9);
		chk("nstart", n_start, 32'h3);
		// Masked event must stay silent, then show once unmasked
		wr(8'h8c, 8'h00, r);
		wr(8'h88, 8'h1f, r);
		pls(4'h2);
		chk("irq", {31'h0, irq}, 32'h0);
		rchk("irqstat", 8'h88, 8'h10);
		wr(8'h8c, 8'h10, r);
		repeat (3) @(posedge aclk);
		chk("irq", {31'h0, irq}, 32'h1);
		wr(8'h88, 8'h10, r);
		repeat (3) @(posedge aclk);
		chk("irq", {31'h0, irq}, 32'h0);
		rchk("irqmask", 8'h8c, 8'h10);
		// Without byte lane 0 the write is dropped but still answered
		ws <= 4'he;
		wr(8'h8c, 8'h1f, r);
		ws <= 4'h1;
		chk("wstrb", {30'h0, r}, {30'h0, `ADF_RESP_OKAY});
		rchk("irqmask", 8'h8c, 8'h10);
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		sweep;
		final_report;
	end
endmodule // adf_status_regs_bench
`default_nettype wire
